// ==== src/fcmc_host.v ====
// Contract
// - bad or misordered cycles need a reset command to recover.
// - host issues reset when timeout flag rises or in autoselect.
// - after buffer abort flag, host sends the abort reset sequence.
// - autoselect only from array or suspend read, not while busy.
// - two unlocks then command; then unlimited identifier reads.
// - query entered by 98h at 55h from array or autoselect.
`include "fcmc_regs.vh"

module fcmc_host #(
  parameter AW = 21,
  parameter DW = 16
) (
  input  wire          clk_sys_in,          // 20 mhz system clock
  input  wire          reset_n_in,          // async reset, active low
  input  wire [2:0]    avs_address_in,      // avalon word address
  input  wire          avs_read_in,         // avalon read request
  input  wire          avs_write_in,        // avalon write request
  input  wire [31:0]   avs_writedata_in,    // avalon write data
  output reg  [31:0]   avs_readdata_out,    // avalon read data
  output wire          avs_waitrequest_out, // avalon stall
  output wire [AW-1:0] fl_addr_out,         // flash address pins
  output wire          fl_ce_n_out,         // flash select, active low
  output wire          fl_we_n_out,         // write strobe, active low
  output wire          fl_oe_n_out,         // output enable, active low
  output wire          fl_byte_n_out,       // low selects byte-wide mode
  output wire [DW-1:0] fl_dq_out,           // data pins driven value
  output wire          fl_dq_oe_out,        // data pins driven while high
  input  wire [DW-1:0] fl_dq_in             // data pins sampled value
);

  localparam S_IDLE = 2'h0;
  localparam S_CYC  = 2'h1;
  localparam S_WAIT = 2'h2;

  reg  [1:0]    state_reg;
  reg  [3:0]    op_reg;
  reg  [1:0]    step_reg;
  reg  [1:0]    mode_reg;
  reg           suspend_reg;
  reg           timeout_reg;
  reg           abort_reg;
  reg           refused_reg;
  reg           embedded_reg;
  reg           byte_mode_reg;
  reg  [DW-1:0] poll_prev_reg;
  reg  [AW-1:0] addr_reg;
  reg  [DW-1:0] wdata_reg;
  reg  [DW-1:0] rdata_reg;
  reg           resp_reg;
  reg           cyc_start_reg;
  reg  [AW-1:0] cyc_addr;
  reg  [DW-1:0] cyc_data;
  reg           cyc_write;
  reg  [1:0]    last_step;
  reg           refuse;
  wire          cyc_done;
  wire [DW-1:0] cyc_rdata;
  wire          req;
  wire          cmd_wr;
  wire [3:0]    new_op;
  wire [AW-1:0] tbl_addr;

  // every access is answered on its second cycle, one wait state
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~resp_reg;
  assign cmd_wr = avs_write_in & ~resp_reg &
                  (avs_address_in == `FCMC_REG_CMD);
  assign new_op = avs_writedata_in[3:0];
  assign fl_byte_n_out = ~byte_mode_reg;

  // table reads in byte-wide mode land at twice the word address
  assign tbl_addr = byte_mode_reg ? {addr_reg[AW-2:0], 1'b0} : addr_reg;

  // commands the device would not accept in its present mode are refused
  always @* begin
    refuse = 1'b0;
    case (new_op)
      `FCMC_OP_AUTOSEL: refuse = (mode_reg != `FCMC_MODE_ARRAY) |
                                 embedded_reg;
      `FCMC_OP_QUERY:   refuse = (mode_reg == `FCMC_MODE_QUERY) |
                                 embedded_reg;
      // a plain reset cannot clear an abort; the abort reset is required
      `FCMC_OP_RESET:   refuse = abort_reg;
      default:          refuse = 1'b0;
    endcase
  end

  // address and data of each bus cycle of the running operation
  always @* begin
    cyc_addr  = addr_reg;
    cyc_data  = wdata_reg;
    cyc_write = 1'b1;
    last_step = 2'h0;
    case (op_reg)
      `FCMC_OP_READ, `FCMC_OP_POLL: begin
        cyc_write = 1'b0;
        last_step = (op_reg == `FCMC_OP_POLL) ? 2'h1 : 2'h0;
        // in autoselect and query any address may be read again
        if (mode_reg != `FCMC_MODE_ARRAY)
          cyc_addr = tbl_addr;
      end
      `FCMC_OP_RESET:   cyc_data = `FCMC_CMD_RESET;
      `FCMC_OP_SUSPEND: cyc_data = `FCMC_CMD_SUSPEND;
      `FCMC_OP_RESUME:  cyc_data = `FCMC_CMD_RESUME;
      `FCMC_OP_QUERY: begin
        cyc_addr = `FCMC_QUERY_ADDR;
        cyc_data = `FCMC_CMD_QUERY;
      end
      `FCMC_OP_AUTOSEL, `FCMC_OP_ABORT_RST: begin
        last_step = 2'h2;
        case (step_reg)
          2'h0: begin
            cyc_addr = `FCMC_UNLOCK_A1;
            cyc_data = `FCMC_UNLOCK_D1;
          end
          2'h1: begin
            cyc_addr = `FCMC_UNLOCK_A2;
            cyc_data = `FCMC_UNLOCK_D2;
          end
          default: begin
            cyc_addr = `FCMC_UNLOCK_A1;
            cyc_data = (op_reg == `FCMC_OP_AUTOSEL) ?
                       `FCMC_CMD_AUTOSEL : `FCMC_CMD_RESET;
          end
        endcase
      end
      default: cyc_data = wdata_reg;
    endcase
  end

  // avalon register writes, command sequencing and mode tracking
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg      <= S_IDLE;
      op_reg         <= `FCMC_OP_READ;
      step_reg       <= 2'h0;
      mode_reg       <= `FCMC_MODE_ARRAY;
      suspend_reg    <= 1'b0;
      timeout_reg    <= 1'b0;
      abort_reg      <= 1'b0;
      refused_reg    <= 1'b0;
      embedded_reg   <= 1'b0;
      byte_mode_reg  <= 1'b0;
      poll_prev_reg  <= {DW{1'b0}};
      addr_reg       <= {AW{1'b0}};
      wdata_reg      <= {DW{1'b0}};
      rdata_reg      <= {DW{1'b0}};
      resp_reg       <= 1'b0;
      cyc_start_reg  <= 1'b0;
    end else begin
      resp_reg      <= req & ~resp_reg;
      cyc_start_reg <= 1'b0;
      if (avs_write_in & ~resp_reg) begin
        case (avs_address_in)
          `FCMC_REG_ADDR:  if (state_reg == S_IDLE)
                             addr_reg <= avs_writedata_in[AW-1:0];
          `FCMC_REG_WDATA: if (state_reg == S_IDLE)
                             wdata_reg <= avs_writedata_in[DW-1:0];
          `FCMC_REG_CFG:   byte_mode_reg <= avs_writedata_in[0];
          // write one to clear the timeout and refused flags; a set below still wins
          `FCMC_REG_STATUS: begin
            if (avs_writedata_in[`FCMC_ST_TIMEOUT]) timeout_reg <= 1'b0;
            if (avs_writedata_in[`FCMC_ST_REFUSED]) refused_reg <= 1'b0;
          end
          default: ;
        endcase
      end
      // mid-sequence commands are refused
      if (cmd_wr & (state_reg != S_IDLE))
        refused_reg <= 1'b1;
      case (state_reg)
        S_IDLE: begin
          if (cmd_wr) begin
            if (refuse) begin
              refused_reg <= 1'b1;
            end else begin
              op_reg         <= new_op;
              step_reg       <= 2'h0;
              cyc_start_reg  <= 1'b1;
              state_reg      <= S_WAIT;
            end
          end
        end
        S_CYC: begin
          cyc_start_reg <= 1'b1;
          state_reg     <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            rdata_reg <= cyc_rdata;
            if (op_reg == `FCMC_OP_POLL) begin
              poll_prev_reg  <= cyc_rdata;
            end
            if (step_reg != last_step) begin
              step_reg  <= step_reg + 2'h1;
              state_reg <= S_CYC;
            end else begin
              state_reg <= S_IDLE;
              case (op_reg)
                // reset keeps the suspend state, so suspend read resumes
                `FCMC_OP_RESET: begin
                  mode_reg     <= `FCMC_MODE_ARRAY;
                  embedded_reg <= 1'b0;
                end
                `FCMC_OP_ABORT_RST: begin
                  mode_reg     <= `FCMC_MODE_ARRAY;
                  abort_reg    <= 1'b0;
                  embedded_reg <= 1'b0;
                end
                `FCMC_OP_AUTOSEL: mode_reg <= `FCMC_MODE_AUTOSEL;
                `FCMC_OP_QUERY:   mode_reg <= `FCMC_MODE_QUERY;
                `FCMC_OP_SUSPEND: begin
                  suspend_reg  <= 1'b1;
                  embedded_reg <= 1'b0;
                end
                `FCMC_OP_RESUME: begin
                  suspend_reg  <= 1'b0;
                  embedded_reg <= 1'b1;
                end
                `FCMC_OP_POLL: begin
                  // toggling status bit means an embedded op still runs
                  embedded_reg <= poll_prev_reg[`FCMC_DQ_TOGGLE] ^
                                  cyc_rdata[`FCMC_DQ_TOGGLE];
                  if (poll_prev_reg[`FCMC_DQ_TOGGLE] ^
                      cyc_rdata[`FCMC_DQ_TOGGLE]) begin
                    if (cyc_rdata[`FCMC_DQ_ABORT])
                      abort_reg <= 1'b1;
                    else if (cyc_rdata[`FCMC_DQ_TIMEOUT]) begin
                      // a timed-out op needs a reset to read again
                      timeout_reg   <= 1'b1;
                      op_reg        <= `FCMC_OP_RESET;
                      step_reg      <= 2'h0;
                      cyc_start_reg <= 1'b1;
                      state_reg     <= S_WAIT;
                    end
                  end
                end
                default: ;
              endcase
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // read data registered in the first cycle of the access
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & ~resp_reg) begin
      case (avs_address_in)
        `FCMC_REG_CMD:    avs_readdata_out <= {28'h0000000, op_reg};
        `FCMC_REG_ADDR:   avs_readdata_out <= {{(32-AW){1'b0}}, addr_reg};
        `FCMC_REG_WDATA:  avs_readdata_out <= {{(32-DW){1'b0}}, wdata_reg};
        `FCMC_REG_RDATA:  avs_readdata_out <= {{(32-DW){1'b0}}, rdata_reg};
        `FCMC_REG_STATUS: avs_readdata_out <= {24'h000000, embedded_reg,
                            refused_reg, abort_reg, timeout_reg,
                            suspend_reg, mode_reg,
                            (state_reg != S_IDLE)};
        `FCMC_REG_CFG:    avs_readdata_out <= {31'h00000000, byte_mode_reg};
        default:          avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  fcmc_bus_cycle #(
    .AW (AW),
    .DW (DW)
  ) u_cycle (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .start_in     (cyc_start_reg),
    .write_in     (cyc_write),
    .addr_in      (cyc_addr),
    .wdata_in     (cyc_data),
    .done_out     (cyc_done),
    .rdata_out    (cyc_rdata),
    .fl_addr_out  (fl_addr_out),
    .fl_ce_n_out  (fl_ce_n_out),
    .fl_we_n_out  (fl_we_n_out),
    .fl_oe_n_out  (fl_oe_n_out),
    .fl_dq_out    (fl_dq_out),
    .fl_dq_oe_out (fl_dq_oe_out),
    .fl_dq_in     (fl_dq_in)
  );

endmodule // fcmc_host

// ==== src/fcmc_regs.vh ====
`ifndef FCMC_REGS_VH
`define FCMC_REGS_VH

// avalon word indices of the controller registers
`define FCMC_REG_CMD      3'h0
`define FCMC_REG_ADDR     3'h1
`define FCMC_REG_WDATA    3'h2
`define FCMC_REG_RDATA    3'h3
`define FCMC_REG_STATUS   3'h4
`define FCMC_REG_CFG      3'h5

// operation codes written to the command register
`define FCMC_OP_READ      4'h0
`define FCMC_OP_WRITE     4'h1
`define FCMC_OP_RESET     4'h2
`define FCMC_OP_AUTOSEL   4'h3
`define FCMC_OP_QUERY     4'h4
`define FCMC_OP_ABORT_RST 4'h5
`define FCMC_OP_SUSPEND   4'h6
`define FCMC_OP_RESUME    4'h7
`define FCMC_OP_POLL      4'h8

// status register bit positions
`define FCMC_ST_BUSY      0
`define FCMC_ST_MODE_LO   1
`define FCMC_ST_MODE_HI   2
`define FCMC_ST_SUSPEND   3
`define FCMC_ST_TIMEOUT   4
`define FCMC_ST_ABORT     5
`define FCMC_ST_REFUSED   6
`define FCMC_ST_EMBEDDED  7

// host view of the device command mode
`define FCMC_MODE_ARRAY   2'h0
`define FCMC_MODE_AUTOSEL 2'h1
`define FCMC_MODE_QUERY   2'h2

// command codes and unlock addresses on the flash bus
`define FCMC_UNLOCK_A1    21'h000555
`define FCMC_UNLOCK_A2    21'h0002aa
`define FCMC_QUERY_ADDR   21'h000055
`define FCMC_UNLOCK_D1    16'h00aa
`define FCMC_UNLOCK_D2    16'h0055
`define FCMC_CMD_RESET    16'h00f0
`define FCMC_CMD_AUTOSEL  16'h0090
`define FCMC_CMD_QUERY    16'h0098
`define FCMC_CMD_SUSPEND  16'h00b0
`define FCMC_CMD_RESUME   16'h0030

// status bits returned by the device while an embedded op runs
`define FCMC_DQ_TOGGLE    6
`define FCMC_DQ_TIMEOUT   5
`define FCMC_DQ_ABORT     1

// bus timing, ns, and derived counts at 20 mhz (least times round up)
`define FCMC_CLK_MHZ      20
`define FCMC_T_WP_NS      50
`define FCMC_T_ACC_NS     100
`define FCMC_WP_CYC  ((`FCMC_T_WP_NS * `FCMC_CLK_MHZ + 999) / 1000)
`define FCMC_ACC_CYC ((`FCMC_T_ACC_NS * `FCMC_CLK_MHZ + 999) / 1000)

`endif

// ==== src/fcmc_bus_cycle.v ====
`include "fcmc_regs.vh"

module fcmc_bus_cycle #(
  parameter AW      = 21,
  parameter DW      = 16,
  parameter WP_CYC  = `FCMC_WP_CYC,
  parameter ACC_CYC = `FCMC_ACC_CYC
) (
  input  wire          clk_sys_in,     // system clock
  input  wire          reset_n_in,     // async reset, active low
  input  wire          start_in,       // one-cycle request pulse
  input  wire          write_in,       // 1 write cycle, 0 read cycle
  input  wire [AW-1:0] addr_in,        // flash address
  input  wire [DW-1:0] wdata_in,       // write data
  output reg           done_out,       // one-cycle completion pulse
  output reg  [DW-1:0] rdata_out,      // captured read data
  output reg  [AW-1:0] fl_addr_out,    // flash address pins
  output reg           fl_ce_n_out,    // flash select, active low
  output reg           fl_we_n_out,    // write strobe, active low
  output reg           fl_oe_n_out,    // output enable, active low
  output reg  [DW-1:0] fl_dq_out,      // data pins driven value
  output reg           fl_dq_oe_out,   // data pins driven while high
  input  wire [DW-1:0] fl_dq_in        // data pins sampled value
);

  localparam S_IDLE  = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_PULSE = 3'h2;
  localparam S_HOLD  = 3'h3;
  localparam S_READ  = 3'h4;

  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg       wr_reg;

  // one bus cycle: the address settles with select low before the write
  // strobe falls, and data is held past the strobe's rise
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg    <= S_IDLE;
      cnt_reg      <= 8'h00;
      wr_reg       <= 1'b0;
      done_out     <= 1'b0;
      rdata_out    <= {DW{1'b0}};
      fl_addr_out  <= {AW{1'b0}};
      fl_ce_n_out  <= 1'b1;
      fl_we_n_out  <= 1'b1;
      fl_oe_n_out  <= 1'b1;
      fl_dq_out    <= {DW{1'b0}};
      fl_dq_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            fl_addr_out  <= addr_in;
            fl_ce_n_out  <= 1'b0;
            fl_dq_out    <= wdata_in;
            fl_dq_oe_out <= write_in;
            wr_reg       <= write_in;
            state_reg    <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (wr_reg) begin
            fl_we_n_out <= 1'b0;
            cnt_reg     <= WP_CYC[7:0];
            state_reg   <= S_PULSE;
          end else begin
            fl_oe_n_out <= 1'b0;
            cnt_reg     <= ACC_CYC[7:0];
            state_reg   <= S_READ;
          end
        end
        S_PULSE: begin
          if (cnt_reg <= 8'h01) begin
            fl_we_n_out <= 1'b1;
            state_reg   <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_READ: begin
          if (cnt_reg <= 8'h01) begin
            rdata_out   <= fl_dq_in;
            fl_oe_n_out <= 1'b1;
            state_reg   <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_HOLD: begin
          // data released one cycle after the strobe rose
          fl_ce_n_out  <= 1'b1;
          fl_dq_oe_out <= 1'b0;
          done_out     <= 1'b1;
          state_reg    <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // fcmc_bus_cycle

// ==== sim/fcmc_properties.sv ====
module fcmc_props #(
  parameter AW = 21,
  parameter DW = 16
) (
  input logic          clk_sys_in,          // system clock
  input logic          reset_n_in,          // async reset, active low
  input logic [2:0]    avs_address_in,      // avalon word address
  input logic          avs_read_in,         // avalon read
  input logic          avs_write_in,        // avalon write
  input logic [31:0]   avs_writedata_in,    // avalon write data
  input logic [31:0]   avs_readdata_out,    // avalon read data
  input logic          avs_waitrequest_out, // avalon stall
  input logic [AW-1:0] fl_addr_out,         // flash address
  input logic          fl_ce_n_out,         // flash select
  input logic          fl_we_n_out,         // write strobe
  input logic          fl_oe_n_out,         // output enable
  input logic          fl_byte_n_out,       // byte-wide select
  input logic [DW-1:0] fl_dq_out,           // driven data
  input logic          fl_dq_oe_out         // data drive enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // exactly one wait state per access
  chk_wait_first: assert property (
    $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out
      ##1 !avs_waitrequest_out) else $error("wait state count wrong");
  // address and data settle before the strobe falls
  chk_we_setup: assert property (
    $fell(fl_we_n_out) |-> !fl_ce_n_out && fl_dq_oe_out
      && $stable(fl_addr_out)) else $error("write setup wrong");
  chk_we_width: assert property (
    $fell(fl_we_n_out) |=> fl_we_n_out) else $error("strobe width wrong");
  // the device latches data on the first rise, so hold it there
  chk_we_frame: assert property (
    $rose(fl_we_n_out) |-> !fl_ce_n_out && fl_dq_oe_out
      && $stable(fl_addr_out) && $stable(fl_dq_out) ##1 fl_ce_n_out)
    else $error("write hold wrong");
  // host drive and device drive never overlap
  chk_bus_clash: assert property (
    fl_dq_oe_out |-> fl_oe_n_out) else $error("data bus contention");
  chk_read_access: assert property (
    $fell(fl_oe_n_out) |-> !fl_oe_n_out ##1 !fl_oe_n_out ##[1:2] fl_oe_n_out)
    else $error("read access time wrong");
  chk_ce_idle: assert property (
    fl_ce_n_out |-> fl_we_n_out && fl_oe_n_out && !fl_dq_oe_out)
    else $error("strobe active while deselected");
  chk_byte_cfg: assert property (
    avs_write_in && !avs_waitrequest_out && avs_address_in == 3'h5
      |=> fl_byte_n_out == !$past(avs_writedata_in[0]))
    else $error("width select does not follow config");
  chk_unmapped_zero: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in > 3'h5
      |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
endmodule // fcmc_props

bind fcmc_host fcmc_props #(.AW(AW), .DW(DW)) chk_u (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .fl_addr_out(fl_addr_out),
  .fl_ce_n_out(fl_ce_n_out), .fl_we_n_out(fl_we_n_out),
  .fl_oe_n_out(fl_oe_n_out), .fl_byte_n_out(fl_byte_n_out),
  .fl_dq_out(fl_dq_out), .fl_dq_oe_out(fl_dq_oe_out)
);

// ==== sim/fcmc_flash_model.sv ====
module fcmc_flash_model #(
  parameter [95:0] IDS = 96'h0 // id words, values chosen by the bench
) (
  input  wire [20:0] fl_addr_in,    // address pins
  input  wire        fl_ce_n_in,    // select
  input  wire        fl_we_n_in,    // write strobe
  input  wire        fl_oe_n_in,    // output enable
  input  wire        fl_byte_n_in,  // low for byte-wide
  input  wire [15:0] fl_dq_in,      // resolved data wire
  input  wire        busy_in,       // embedded op running
  input  wire        dq5_in,        // timeout flag value
  input  wire        dq1_in,        // buffer abort flag value
  output reg  [15:0] fl_dq_out,     // device data drive
  output reg  [7:0]  n_reset_out    // accepted reset commands
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam [271:0] QT = {16'h0050, 16'h0052, 16'h0049, 16'h0031,
    16'h0033, 16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000,
    16'h0000, 16'h0001, 16'h00b5, 16'h00c5, 16'h0003, 16'h0001};
  wire        strobe_n = fl_we_n_in | fl_ce_n_in;
  wire [20:0] ix = fl_byte_n_in ? fl_addr_in : fl_addr_in >> 1;
  wire [7:0]  k = ix[7:0] - 8'h40;
  wire [7:0]  d = fl_dq_in[7:0];
  reg  [20:0] cmd_addr;
  reg  [1:0]  mode; // 0 array, 1 ids, 2 query
  reg  [1:0]  step;
  reg         susp, tog;
  reg  [15:0] val, last;
  initial begin
    mode = 2'h0; step = 2'h0; susp = 1'b0; tog = 1'b0;
    last = 16'h0; n_reset_out = 8'h0; cmd_addr = 21'h0;
  end
  // address at the later fall, data at the first rise of the two strobes
  always @(negedge strobe_n) cmd_addr = fl_addr_in;
  always @(posedge strobe_n) begin
    if (d == 8'hf0) begin
      // a running op ignores reset unless it has failed or aborted
      if (!busy_in || dq5_in || dq1_in) begin
        mode = 2'h0; step = 2'h0; n_reset_out = n_reset_out + 8'h1;
      end
    end else if (busy_in) step = 2'h0;
    else if (d == 8'h98 && cmd_addr[7:0] == 8'h55) mode = 2'h2;
    else if (d == 8'hb0) susp = 1'b1;
    else if (d == 8'h30) susp = 1'b0;
    else if (step == 2'h0 && cmd_addr == 21'h555 && d == 8'haa) step = 2'h1;
    else if (step == 2'h1 && cmd_addr == 21'h2aa && d == 8'h55) step = 2'h2;
    else if (step == 2'h2 && cmd_addr == 21'h555 && d == 8'h90
      && mode == 2'h0) begin
      mode = 2'h1; step = 2'h0;
    end else step = 2'h0;
  end
  // read data; a released bus shows the inverse of the last word
  always @* begin
    case (mode)
      2'h1: case (ix[7:0])
        8'h00: val = IDS[95:80];
        8'h01: val = IDS[79:64];
        8'h0e: val = IDS[63:48];
        8'h0f: val = IDS[47:32];
        8'h03: val = IDS[31:16];
        8'h02: val = IDS[15:0];
        default: val = 16'h0;
      endcase
      2'h2: val = (k < 8'h11) ? QT[(16 - k) * 16 +: 16] : 16'h0;
      default: val = fl_addr_in[15:0] ^ 16'h5a5a;
    endcase
    if (busy_in) val = {9'h0, tog, dq5_in, 3'h0, dq1_in, 1'b0};
    fl_dq_out = (!fl_ce_n_in && !fl_oe_n_in) ? val : ~last;
  end
  always @(posedge fl_oe_n_in) begin
    last = val;
    tog = ~tog;
  end
endmodule // fcmc_flash_model

// ==== sim/testbench.sv ====
`include "fcmc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [95:0] IDS = 96'h00c3_0a11_0a22_0a33_0001_0001; // arbitrary
  localparam [271:0] QT = {16'h0050, 16'h0052, 16'h0049, 16'h0031,
    16'h0033, 16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000,
    16'h0000, 16'h0001, 16'h00b5, 16'h00c5, 16'h0003, 16'h0001};
  logic        clk_sys_in, reset_n_in, av_rd, av_wr;
  logic [2:0]  av_addr;
  logic [31:0] av_wdata, rdq;
  logic        busy_sim, dq5_sim, dq1_sim;
  logic [7:0]  nr;
  int          miscompares, n_checks, cycles;
  wire  [31:0] av_rdata;
  wire         av_wait, ce_n, we_n, oe_n, byte_n, dq_oe;
  wire  [20:0] fl_addr;
  wire  [15:0] host_dq, dev_dq;
  wire  [7:0]  n_reset;
  wire  [15:0] dq_bus = dq_oe ? host_dq : dev_dq; // no pull on this bus
  fcmc_host dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
    .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(av_wait), .fl_addr_out(fl_addr),
    .fl_ce_n_out(ce_n), .fl_we_n_out(we_n), .fl_oe_n_out(oe_n),
    .fl_byte_n_out(byte_n), .fl_dq_out(host_dq), .fl_dq_oe_out(dq_oe),
    .fl_dq_in(dq_bus));
  fcmc_flash_model #(.IDS(IDS)) dev_u (.fl_addr_in(fl_addr),
    .fl_ce_n_in(ce_n), .fl_we_n_in(we_n), .fl_oe_n_in(oe_n),
    .fl_byte_n_in(byte_n), .fl_dq_in(dq_bus), .busy_in(busy_sim),
    .dq5_in(dq5_sim), .dq1_in(dq1_sim), .fl_dq_out(dev_dq),
    .n_reset_out(n_reset));
  always #25 clk_sys_in = ~clk_sys_in;
  // watchdog: the whole sequence needs about a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon access; waitrequest is judged as it stands before the edge
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    av_addr <= a; av_wdata <= d; av_wr <= wr; av_rd <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (av_wait !== 1'b0);
    check("wait states", n - 1, 1);
    rdq = av_rdata;
    av_wr <= 1'b0; av_rd <= 1'b0;
  endtask
  task automatic st;
    av(0, `FCMC_REG_STATUS, 0);
  endtask
  // load address and data, issue an op, wait for busy to clear
  task automatic op(input logic [3:0] c, input logic [20:0] a);
    int n;
    av(1, `FCMC_REG_ADDR, 32'(a));
    av(1, `FCMC_REG_WDATA, 32'h0);
    av(1, `FCMC_REG_CMD, 32'(c));
    n = 0;
    do begin
      st;
      n++;
    end while (rdq[`FCMC_ST_BUSY] !== 1'b0 && n < 60);
    if (n >= 60) begin
      check("busy", 1, 0);
      tally_and_finish;
    end
  endtask
  task automatic fread(input logic [20:0] a);
    op(`FCMC_OP_READ, a);
    av(0, `FCMC_REG_RDATA, 0);
  endtask
  initial begin
    logic [20:0] ida [6];
    ida = '{21'h00, 21'h01, 21'h0e, 21'h0f, 21'h03, 21'h10002};
    clk_sys_in = 1'b0; reset_n_in = 1'b0; av_rd = 1'b0; av_wr = 1'b0;
    av_addr = 3'h0; av_wdata = 32'h0; cycles = 0;
    busy_sim = 1'b0; dq5_sim = 1'b0; dq1_sim = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    check("idle select", ce_n, 1);
    st;
    check("status reset", rdq, 0);
    fread(21'h01234);
    check("array read", rdq, 32'h1234 ^ 32'h5a5a);
    av(1, `FCMC_REG_CMD, 0);
    av(1, `FCMC_REG_CMD, 0);
    st;
    check("busy cmd", rdq[`FCMC_ST_REFUSED], 1);
    av(1, `FCMC_REG_STATUS, 32'h40);
    op(`FCMC_OP_QUERY, 0);
    st;
    check("mode query", rdq[2:1], `FCMC_MODE_QUERY);
    for (int k = 0; k < 17; k++) begin
      fread(21'h40 + k);
      check("query word", rdq, 32'(QT[(16 - k) * 16 +: 16]));
    end
    op(`FCMC_OP_QUERY, 0);
    st;
    check("refused", rdq[`FCMC_ST_REFUSED], 1);
    av(1, `FCMC_REG_STATUS, 32'h40);
    av(1, `FCMC_REG_CFG, 32'h1);
    fread(21'h45);
    check("byte query", rdq, 32'h8);
    av(1, `FCMC_REG_CFG, 32'h0);
    op(`FCMC_OP_RESET, 21'h1abcd);
    st;
    check("mode array", rdq[2:1], `FCMC_MODE_ARRAY);
    op(`FCMC_OP_AUTOSEL, 0);
    for (int k = 0; k < 6; k++) begin
      fread(ida[k]);
      check("id word", rdq, 32'(IDS[(5 - k) * 16 +: 16]));
    end
    fread(21'h0);
    check("id again", rdq, 32'(IDS[95:80]));
    op(`FCMC_OP_QUERY, 0);
    fread(21'h40);
    check("query from ids", rdq, 32'h50);
    op(`FCMC_OP_RESET, 21'h00300);
    fread(21'h00777);
    check("array again", rdq, 32'h0777 ^ 32'h5a5a);
    op(`FCMC_OP_SUSPEND, 0);
    op(`FCMC_OP_AUTOSEL, 0);
    st;
    check("mode ids", rdq[2:1], `FCMC_MODE_AUTOSEL);
    op(`FCMC_OP_RESET, 0);
    st;
    check("mode array", rdq[2:1], `FCMC_MODE_ARRAY);
    check("suspend kept", rdq[`FCMC_ST_SUSPEND], 1);
    op(`FCMC_OP_RESUME, 0);
    op(`FCMC_OP_AUTOSEL, 0);
    st;
    check("refused busy", rdq[`FCMC_ST_REFUSED], 1);
    av(1, `FCMC_REG_STATUS, 32'h40);
    op(`FCMC_OP_POLL, 0);
    st;
    check("op done", rdq[`FCMC_ST_EMBEDDED], 0);
    nr = n_reset;
    busy_sim <= 1'b1;
    dq5_sim <= 1'b1;
    op(`FCMC_OP_POLL, 21'h00100);
    st;
    check("timeout", rdq[`FCMC_ST_TIMEOUT], 1);
    check("auto reset", 32'(n_reset), 32'(nr + 8'h1));
    dq5_sim <= 1'b0;
    dq1_sim <= 1'b1;
    av(1, `FCMC_REG_STATUS, 32'h10);
    op(`FCMC_OP_POLL, 0);
    st;
    check("abort", rdq[`FCMC_ST_ABORT], 1);
    check("timeout clear", rdq[`FCMC_ST_TIMEOUT], 0);
    op(`FCMC_OP_RESET, 0);
    st;
    check("plain reset", rdq[`FCMC_ST_REFUSED], 1);
    nr = n_reset;
    op(`FCMC_OP_ABORT_RST, 0);
    st;
    check("abort clear", rdq[`FCMC_ST_ABORT], 0);
    check("abort reset", 32'(n_reset), 32'(nr + 8'h1));
    busy_sim <= 1'b0;
    dq1_sim <= 1'b0;
    av(1, 3'h6, 32'hffff_ffff);
    av(0, 3'h6, 0);
    check("unmapped", rdq, 0);
    tally_and_finish;
  end
endmodule // testbench
